/* sfpes_pkg.sv */
// Shared constants and types for the serial flash command interpreter
package sfpes_pkg;

  localparam int unsigned CLK_MHZ = 20;

  // Command opcodes
  localparam logic [7:0] OP_WRITE_UNLOCK      = 8'h06;
  localparam logic [7:0] OP_WRITE_LOCK        = 8'h04;
  localparam logic [7:0] OP_PAGE_WRITE        = 8'h02;
  localparam logic [7:0] OP_QUAD_PAGE_WRITE   = 8'h32;
  localparam logic [7:0] OP_SMALL_ERASE       = 8'h20;
  localparam logic [7:0] OP_DOUBLE_SMALL      = 8'h40;
  localparam logic [7:0] OP_BLOCK_WIPE        = 8'hd8;
  localparam logic [7:0] OP_FULL_ARRAY_WIPE   = 8'hc7;
  localparam logic [7:0] OP_SLEEP_ENTRY       = 8'hb9;
  localparam logic [7:0] OP_WAKE_SIGNATURE    = 8'hab;

  // Frame lengths in single-lane bits, then data bits taken per clock edge
  localparam logic [5:0] OPCODE_BITS          = 6'h08;
  localparam logic [5:0] HEADER_BITS          = 6'h20;
  localparam logic [2:0] QUAD_STEP            = 3'h4;
  localparam logic [2:0] SINGLE_STEP          = 3'h1;

  // Signature byte, value arbitrary
  localparam logic [7:0] SIGNATURE            = 8'h5a;
  localparam logic [2:0] SIG_MSB              = 3'h7;

  // Address geometry
  localparam logic [6:0] PARAM_REGION         = 7'h00;
  localparam logic [6:0] ALL_SECTORS_MASK     = 7'h7f;
  localparam logic [2:0] GUARD_SHIFT_TOP      = 3'h7;
  localparam logic [2:0] GUARD_NONE           = 3'h0;
  localparam logic [23:0] PAGE_MASK           = 24'h0000ff;
  localparam logic [23:0] MASK_4K             = 24'h000fff;
  localparam logic [23:0] MASK_8K             = 24'h001fff;
  localparam logic [23:0] MASK_64K            = 24'h00ffff;
  localparam logic [23:0] ARRAY_LAST          = 24'h7fffff;
  localparam logic [23:0] ARRAY_FIRST         = 24'h000000;
  localparam logic [7:0] ERASED_BYTE          = 8'hff;
  localparam int unsigned PAGE_BYTES          = 256;

  // Self-timed durations in microseconds, then cycles
  localparam int unsigned PAGE_WRITE_TIME_US   = 100;
  localparam int unsigned SECTOR_ERASE_TIME_US = 1000;
  localparam int unsigned ARRAY_WIPE_TIME_US   = 10000;
  localparam int unsigned SLEEP_ENTRY_DELAY_US = 3;
  localparam int unsigned WAKE_DELAY_US        = 3;
  localparam int unsigned PAGE_WRITE_CYCLES    = PAGE_WRITE_TIME_US * CLK_MHZ;
  localparam int unsigned SECTOR_ERASE_CYCLES  = SECTOR_ERASE_TIME_US * CLK_MHZ;
  localparam int unsigned ARRAY_WIPE_CYCLES    = ARRAY_WIPE_TIME_US * CLK_MHZ;
  localparam logic [31:0] SLEEP_ENTRY_CYCLES   = 32'(SLEEP_ENTRY_DELAY_US * CLK_MHZ);
  localparam logic [31:0] WAKE_CYCLES          = 32'(WAKE_DELAY_US * CLK_MHZ);
  localparam logic [31:0] TIMER_ZERO           = 32'h00000000;
  localparam logic [31:0] TIMER_ONE            = 32'h00000001;

  typedef enum logic [2:0] {
    ST_STANDBY,
    ST_BUSY,
    ST_SLEEP_WAIT,
    ST_SLEEP,
    ST_WAKE_WAIT
  } sfpes_state_t;

  typedef enum logic [1:0] {
    OPK_NONE,
    OPK_PROGRAM,
    OPK_ERASE
  } sfpes_op_t;

endpackage : sfpes_pkg

/* sfpes_page_mem.sv */
// Page staging memory with registered read data
`timescale 1ns/1ps
module sfpes_page_mem (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_idx,
  input  wire logic [7:0] wr_data,
  input  wire logic [7:0] rd_idx,
  output logic      [7:0] rd_data
);

  logic [7:0] mem [0:sfpes_pkg::PAGE_BYTES-1];

  // No reset on the array, it is qualified by valid flags outside
  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data <= sfpes_pkg::ERASED_BYTE;
    end else begin
      rd_data <= mem[rd_idx];
    end
  end

endmodule : sfpes_page_mem

/* sfpes_core.sv */
// Serial flash program, erase and deep sleep command interpreter
`timescale 1ns/1ps
module sfpes_core #(
  parameter int unsigned PAGE_WRITE_CYCLES   = sfpes_pkg::PAGE_WRITE_CYCLES,
  parameter int unsigned SECTOR_ERASE_CYCLES = sfpes_pkg::SECTOR_ERASE_CYCLES,
  parameter int unsigned ARRAY_WIPE_CYCLES   = sfpes_pkg::ARRAY_WIPE_CYCLES
) (
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  input  wire logic                 cs_n,
  input  wire logic                 sck,
  input  wire logic [3:0]           io_in,
  input  wire logic                 quad_enable,
  input  wire logic [2:0]           block_guard_bits,
  input  wire logic [7:0]           pg_rd_idx,
  output logic                      so_out,
  output logic                      so_oe,
  output logic                      busy_flag,
  output logic                      write_latch,
  output logic                      deep_sleep,
  output logic                      op_start,
  output sfpes_pkg::sfpes_op_t      op_kind,
  output logic [23:0]               op_base,
  output logic [23:0]               op_last,
  output logic [7:0]                pg_rd_data
);

  // Pin synchronisers, first stage read only by second
  logic       sck_m;
  logic       sck_s;
  logic       sck_d;
  logic       cs_m;
  logic       cs_s;
  logic       cs_d;
  logic [3:0] io_m;
  logic [3:0] io_s;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sck_m <= 1'b0;
      sck_s <= 1'b0;
      sck_d <= 1'b0;
      cs_m  <= 1'b1;
      cs_s  <= 1'b1;
      cs_d  <= 1'b1;
      io_m  <= 4'h0;
      io_s  <= 4'h0;
    end else begin
      sck_m <= sck;
      sck_s <= sck_m;
      sck_d <= sck_s;
      cs_m  <= cs_n;
      cs_s  <= cs_m;
      cs_d  <= cs_s;
      io_m  <= io_in;
      io_s  <= io_m;
    end
  end

  // Io and clock share the same sync delay, so data stays aligned
  wire sck_rise  = sck_s & ~sck_d & ~cs_s;
  wire sck_fall  = ~sck_s & sck_d & ~cs_s;
  wire frame_end = cs_s & ~cs_d;

  // Link framing state
  sfpes_pkg::sfpes_state_t state;
  sfpes_pkg::sfpes_state_t next_state;
  logic [5:0]  bcnt;
  logic [23:0] sh;
  logic [7:0]  opcode;
  logic        over;
  logic        got_byte;
  logic [2:0]  dcnt;
  logic [7:0]  dbyte;
  logic [7:0]  wr_idx;
  logic [2:0]  sig_idx;

  wire [7:0] shift_in    = {sh[6:0], io_s[0]};
  wire       hdr_phase   = bcnt < sfpes_pkg::HEADER_BITS;
  wire       is_quad     = opcode == sfpes_pkg::OP_QUAD_PAGE_WRITE;
  wire       is_write_op = is_quad | (opcode == sfpes_pkg::OP_PAGE_WRITE);
  wire       standby     = state == sfpes_pkg::ST_STANDBY;

  // Buffer only moves in standby; a running program is reading it
  wire       data_rise   = sck_rise & ~hdr_phase & is_write_op & standby;
  wire [2:0] dstep       = is_quad ? sfpes_pkg::QUAD_STEP : sfpes_pkg::SINGLE_STEP;
  wire [3:0] dsum        = {1'b0, dcnt} + {1'b0, dstep};
  wire       byte_done   = data_rise & dsum[3];
  wire [7:0] next_dbyte  = is_quad ? {dbyte[3:0], io_s} : {dbyte[6:0], io_s[0]};
  wire       buf_clear   = sck_rise & (bcnt == sfpes_pkg::OPCODE_BITS) & is_write_op
                           & standby;
  wire       sig_go      = ~hdr_phase & (opcode == sfpes_pkg::OP_WAKE_SIGNATURE)
                           & (state != sfpes_pkg::ST_BUSY);

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      bcnt     <= 6'h00;
      sh       <= 24'h000000;
      opcode   <= 8'h00;
      over     <= 1'b0;
      got_byte <= 1'b0;
      dcnt     <= 3'h0;
      dbyte    <= 8'h00;
      wr_idx   <= 8'h00;
      sig_idx  <= sfpes_pkg::SIG_MSB;
    end else if (cs_s) begin
      bcnt     <= 6'h00;
      over     <= 1'b0;
      got_byte <= 1'b0;
      dcnt     <= 3'h0;
      sig_idx  <= sfpes_pkg::SIG_MSB;
    end else begin
      if (sck_rise) begin
        if (hdr_phase) begin
          sh   <= {sh[22:0], io_s[0]};
          bcnt <= 6'(bcnt + 6'h01);
        end else begin
          over <= 1'b1;
        end
        if (bcnt == sfpes_pkg::OPCODE_BITS - 6'h01) begin
          opcode <= shift_in;
        end
        if (bcnt == sfpes_pkg::HEADER_BITS - 6'h01) begin
          wr_idx <= shift_in;
        end
      end
      if (data_rise) begin
        dcnt  <= dsum[2:0];
        dbyte <= next_dbyte;
        if (dsum[3]) begin
          got_byte <= 1'b1;
          wr_idx   <= 8'(wr_idx + 8'h01);
        end
      end
      if (sck_fall & sig_go) begin
        sig_idx <= 3'(sig_idx - 3'h1);
      end
    end
  end

  // Signature lane, repeats as long as the host clocks
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      so_out <= 1'b0;
      so_oe  <= 1'b0;
    end else if (cs_s) begin
      so_oe  <= 1'b0;
    end else if (sck_fall & sig_go) begin
      so_oe  <= 1'b1;
      so_out <= sfpes_pkg::SIGNATURE[sig_idx];
    end
  end

  // Page staging: per-byte valid flags, unwritten bytes read as erased
  logic [sfpes_pkg::PAGE_BYTES-1:0] buf_valid;
  logic       pg_valid_q;
  logic [7:0] mem_q;

  genvar gi;
  generate
    for (gi = 0; gi < sfpes_pkg::PAGE_BYTES; gi = gi + 1) begin : g_valid
      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          buf_valid[gi] <= 1'b0;
        end else if (buf_clear) begin
          buf_valid[gi] <= 1'b0;
        end else if (byte_done && wr_idx == 8'(gi)) begin
          buf_valid[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  sfpes_page_mem u_page_mem (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .wr_en   (byte_done),
    .wr_idx  (wr_idx),
    .wr_data (next_dbyte),
    .rd_idx  (pg_rd_idx),
    .rd_data (mem_q)
  );

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pg_valid_q <= 1'b0;
      pg_rd_data <= sfpes_pkg::ERASED_BYTE;
    end else begin
      pg_valid_q <= buf_valid[pg_rd_idx];
      pg_rd_data <= pg_valid_q ? mem_q : sfpes_pkg::ERASED_BYTE;
    end
  end

  // Frame-end command checks
  wire [23:0] addr         = sh;
  wire [6:0]  sector       = addr[22:16];
  // Top 2^b sectors share their upper 7-b sector bits, all ones
  wire [6:0]  prot_mask    = sfpes_pkg::ALL_SECTORS_MASK << block_guard_bits;
  wire        guard_off    = block_guard_bits == sfpes_pkg::GUARD_NONE;
  wire        sector_prot  = ~guard_off & ((sector & prot_mask) == prot_mask);
  wire        param_sector = addr[23:17] == sfpes_pkg::PARAM_REGION;
  wire        exact_cmd    = bcnt == sfpes_pkg::OPCODE_BITS;
  wire        exact_hdr    = (bcnt == sfpes_pkg::HEADER_BITS) & ~over;
  wire        data_ok      = (bcnt == sfpes_pkg::HEADER_BITS) & got_byte & (dcnt == 3'h0);
  wire        can_modify   = write_latch & ~sector_prot;

  wire go_prog   = ((opcode == sfpes_pkg::OP_PAGE_WRITE) | (is_quad & quad_enable))
                   & data_ok & can_modify;
  wire go_small  = (opcode == sfpes_pkg::OP_SMALL_ERASE) & exact_hdr & can_modify
                   & param_sector;
  wire go_double = (opcode == sfpes_pkg::OP_DOUBLE_SMALL) & exact_hdr & can_modify
                   & param_sector;
  wire go_wipe   = (opcode == sfpes_pkg::OP_BLOCK_WIPE) & exact_hdr & can_modify;
  wire go_full   = (opcode == sfpes_pkg::OP_FULL_ARRAY_WIPE) & exact_cmd & write_latch
                   & guard_off;
  wire go_sleep  = (opcode == sfpes_pkg::OP_SLEEP_ENTRY) & exact_cmd;
  wire go_wake   = (opcode == sfpes_pkg::OP_WAKE_SIGNATURE) & (bcnt >= sfpes_pkg::OPCODE_BITS);
  wire go_unlock = (opcode == sfpes_pkg::OP_WRITE_UNLOCK) & exact_cmd;
  wire go_lock   = (opcode == sfpes_pkg::OP_WRITE_LOCK) & exact_cmd;
  wire go_op     = go_prog | go_small | go_double | go_wipe | go_full;

  // Region of the accepted operation; 8 kB mask drops A12 for the pair
  wire [23:0] erase_mask = (opcode == sfpes_pkg::OP_SMALL_ERASE) ? sfpes_pkg::MASK_4K :
                           (opcode == sfpes_pkg::OP_DOUBLE_SMALL) ? sfpes_pkg::MASK_8K :
                           sfpes_pkg::MASK_64K;
  wire [23:0] span_mask  = go_full ? sfpes_pkg::ARRAY_LAST :
                           go_prog ? sfpes_pkg::PAGE_MASK : erase_mask;
  wire [23:0] next_base  = go_full ? sfpes_pkg::ARRAY_FIRST : (addr & ~span_mask);
  wire [23:0] next_last  = next_base | span_mask;
  wire [31:0] op_cycles  = go_prog ? 32'(PAGE_WRITE_CYCLES) :
                           go_full ? 32'(ARRAY_WIPE_CYCLES) : 32'(SECTOR_ERASE_CYCLES);
  wire        launch     = standby & frame_end & go_op;

  // Power and operation sequencer
  logic [31:0] timer;
  logic [31:0] next_timer;
  logic        next_latch;
  wire         timer_done = timer == sfpes_pkg::TIMER_ZERO;

  always_comb begin
    next_state = state;
    next_latch = write_latch;
    next_timer = timer_done ? timer : 32'(timer - sfpes_pkg::TIMER_ONE);
    case (state)
      sfpes_pkg::ST_STANDBY: begin
        if (frame_end) begin
          if (go_op) begin
            next_state = sfpes_pkg::ST_BUSY;
            next_timer = 32'(op_cycles - sfpes_pkg::TIMER_ONE);
            next_latch = 1'b0;
          end else if (go_sleep) begin
            next_state = sfpes_pkg::ST_SLEEP_WAIT;
            next_timer = sfpes_pkg::SLEEP_ENTRY_CYCLES - sfpes_pkg::TIMER_ONE;
          end else if (go_unlock) begin
            next_latch = 1'b1;
          end else if (go_lock) begin
            next_latch = 1'b0;
          end
        end
      end
      // Every command, sleep and wake included, is dropped here
      sfpes_pkg::ST_BUSY: begin
        if (timer_done) begin
          next_state = sfpes_pkg::ST_STANDBY;
        end
      end
      sfpes_pkg::ST_SLEEP_WAIT: begin
        if (frame_end & go_wake) begin
          next_state = sfpes_pkg::ST_WAKE_WAIT;
          next_timer = sfpes_pkg::WAKE_CYCLES - sfpes_pkg::TIMER_ONE;
        end else if (timer_done) begin
          next_state = sfpes_pkg::ST_SLEEP;
        end
      end
      sfpes_pkg::ST_SLEEP: begin
        if (frame_end & go_wake) begin
          next_state = sfpes_pkg::ST_WAKE_WAIT;
          next_timer = sfpes_pkg::WAKE_CYCLES - sfpes_pkg::TIMER_ONE;
        end
      end
      // Host must not send work until this ends
      sfpes_pkg::ST_WAKE_WAIT: begin
        if (timer_done) begin
          next_state = sfpes_pkg::ST_STANDBY;
        end
      end
      default: begin
        next_state = sfpes_pkg::ST_STANDBY;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state       <= sfpes_pkg::ST_STANDBY;
      timer       <= sfpes_pkg::TIMER_ZERO;
      write_latch <= 1'b0;
      busy_flag   <= 1'b0;
      deep_sleep  <= 1'b0;
    end else begin
      state       <= next_state;
      timer       <= next_timer;
      write_latch <= next_latch;
      busy_flag   <= next_state == sfpes_pkg::ST_BUSY;
      deep_sleep  <= next_state == sfpes_pkg::ST_SLEEP;
    end
  end

  // Command to the array, one pulse per accepted operation
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      op_start <= 1'b0;
      op_kind  <= sfpes_pkg::OPK_NONE;
      op_base  <= sfpes_pkg::ARRAY_FIRST;
      op_last  <= sfpes_pkg::ARRAY_FIRST;
    end else begin
      op_start <= launch;
      if (launch) begin
        op_kind <= go_prog ? sfpes_pkg::OPK_PROGRAM : sfpes_pkg::OPK_ERASE;
        op_base <= next_base;
        op_last <= next_last;
      end
    end
  end

endmodule : sfpes_core

/* sfpes_checker.sv */
// Port assertions for the flash command core
`timescale 1ns/1ps
module sfpes_checker #(
  parameter int unsigned PAGE_WRITE_CYCLES   = 20,
  parameter int unsigned SECTOR_ERASE_CYCLES = 40,
  parameter int unsigned ARRAY_WIPE_CYCLES   = 80
) (
  input wire logic                 clk_sys,
  input wire logic                 sys_rst,
  input wire logic                 cs_n,
  input wire logic [2:0]           block_guard_bits,
  input wire logic                 so_oe,
  input wire logic                 busy_flag,
  input wire logic                 write_latch,
  input wire logic                 deep_sleep,
  input wire logic                 op_start,
  input wire sfpes_pkg::sfpes_op_t op_kind,
  input wire logic [23:0]          op_base,
  input wire logic [23:0]          op_last
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  logic [31:0] blen;
  logic [31:0] exp_len;
  logic [7:0]  guard_lo;
  logic        wipe_all;
  logic        in_par;
  logic        shape;
  assign wipe_all = op_base == 24'h0 && op_last == sfpes_pkg::ARRAY_LAST;
  assign in_par = op_base[23:17] == 7'h00;
  // Array wipe is the only erase longer than a sector
  assign exp_len = op_kind == sfpes_pkg::OPK_PROGRAM ? 32'(PAGE_WRITE_CYCLES)
                 : wipe_all ? 32'(ARRAY_WIPE_CYCLES) : 32'(SECTOR_ERASE_CYCLES);
  assign guard_lo = 8'h80 - (8'h01 << block_guard_bits);
  assign shape = wipe_all || (op_base[15:0] == 16'h0 && op_last == (op_base | 24'h00ffff))
               || (in_par && op_base[11:0] == 12'h0 && op_last == (op_base | 24'h000fff))
               || (in_par && op_base[12:0] == 13'h0 && op_last == (op_base | 24'h001fff));
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) blen <= 32'h0;
    else if (busy_flag) blen <= blen + 32'h1;
    else blen <= 32'h0;
  end
  sequence s_cs_rise;
    $rose(cs_n);
  endsequence
  sequence s_oe_off;
    ##[1:6] !so_oe;
  endsequence
  a_busy_time: assert property ($fell(busy_flag) |-> blen == exp_len)
    else $error("busy length wrong");
  a_start_state: assert property (op_start |-> busy_flag && !write_latch)
    else $error("start without busy");
  a_start_latch: assert property (op_start |-> $past(write_latch))
    else $error("start without latch");
  a_start_idle: assert property (op_start |-> !$past(busy_flag))
    else $error("start while busy");
  a_start_framed: assert property (op_start |-> cs_n && $past(cs_n))
    else $error("start inside frame");
  a_busy_mute: assert property (busy_flag |-> !so_oe)
    else $error("output while busy");
  a_oe_release: assert property (s_cs_rise |-> s_oe_off)
    else $error("output held after select");
  a_wake_latch: assert property ($fell(deep_sleep) |-> $stable(write_latch))
    else $error("wake changed latch");
  a_prog_page: assert property (op_start && op_kind == sfpes_pkg::OPK_PROGRAM
    |-> op_base[7:0] == 8'h00 && op_last == (op_base | 24'h0000ff))
    else $error("program range wrong");
  a_erase_shape: assert property (op_start && op_kind == sfpes_pkg::OPK_ERASE
    |-> shape) else $error("erase range wrong");
  a_guard_hold: assert property (op_start && block_guard_bits != 3'h0
    |-> {1'b0, op_last[22:16]} < guard_lo) else $error("guarded sector touched");
endmodule : sfpes_checker

bind sfpes_core sfpes_checker #(
  .PAGE_WRITE_CYCLES(PAGE_WRITE_CYCLES),
  .SECTOR_ERASE_CYCLES(SECTOR_ERASE_CYCLES),
  .ARRAY_WIPE_CYCLES(ARRAY_WIPE_CYCLES)
) i_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .cs_n(cs_n), .block_guard_bits(block_guard_bits),
  .so_oe(so_oe), .busy_flag(busy_flag), .write_latch(write_latch), .deep_sleep(deep_sleep),
  .op_start(op_start), .op_kind(op_kind), .op_base(op_base), .op_last(op_last)
);

/* sfpes_host.sv */
// Host controller model framing link commands
`timescale 1ns/1ps
module sfpes_host (
  output logic       cs_n,
  output logic       sck,
  output logic [3:0] io_in,
  input  wire logic  so_out
);
  logic [7:0]  dat [512];
  logic [15:0] rx;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    io_in = 4'h0;
  end
  // Sample reply just before the fall that shifts the next bit
  task automatic tick(input logic [3:0] v);
    io_in = v;
    #200 sck = 1'b1;
    #190 rx = {rx[14:0], so_out};
    #10 sck = 1'b0;
  endtask : tick
  task automatic frame(input logic [39:0] hdr, input int hb, input int nb, input logic quad);
    cs_n = 1'b0;
    #200;
    for (int i = 0; i < hb; i++) tick({3'h0, hdr[39-i]});
    for (int i = 0; i < nb; i++) begin
      if (quad) begin
        tick(dat[i][7:4]);
        tick(dat[i][3:0]);
      end else begin
        for (int j = 7; j >= 0; j--) tick({3'h0, dat[i][j]});
      end
    end
    #200 cs_n = 1'b1;
    io_in = ~io_in;
    #600;
  endtask : frame
endmodule : sfpes_host

/* tb_top.sv */
// Self-checking bench for the flash command core
`timescale 1ns/1ps
module tb_top;
  localparam int unsigned AW = 1000;
  typedef struct packed {
    logic [7:0]  op;
    logic [7:0]  hb;
    logic [2:0]  guard;
    logic [23:0] addr;
    logic [23:0] base;
    logic [23:0] last;
  } sfpes_case_t;
  logic        clk_sys;
  logic        sys_rst;
  logic        quad_enable;
  logic [2:0]  block_guard_bits;
  logic [7:0]  pg_rd_idx;
  logic        cs_n;
  logic        sck;
  logic [3:0]  io_in;
  logic        so_out;
  logic        so_oe;
  logic        busy_flag;
  logic        write_latch;
  logic        deep_sleep;
  logic        op_start;
  logic [23:0] op_base;
  logic [23:0] op_last;
  logic [7:0]  pg_rd_data;
  logic [49:0] exp_q [$];
  logic [7:0]  exp_pg [256];
  logic [31:0] seed = 32'h2962596d;
  int          n_errors = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  sfpes_pkg::sfpes_op_t op_kind;
  // Refused cases carry a zero last address
  sfpes_case_t tc [12] = '{
    '{8'h20, 8'h20, 3'h0, 24'h001abc, 24'h001000, 24'h001fff},
    '{8'h20, 8'h1f, 3'h0, 24'h001abc, 24'h0, 24'h0},
    '{8'h20, 8'h20, 3'h0, 24'h020000, 24'h0, 24'h0},
    '{8'h20, 8'h20, 3'h7, 24'h000000, 24'h0, 24'h0},
    '{8'h40, 8'h20, 3'h0, 24'h003456, 24'h002000, 24'h003fff},
    '{8'hd8, 8'h20, 3'h0, 24'h001234, 24'h000000, 24'h00ffff},
    '{8'hd8, 8'h21, 3'h0, 24'h001234, 24'h0, 24'h0},
    '{8'hd8, 8'h20, 3'h1, 24'h7f0000, 24'h0, 24'h0},
    '{8'hd8, 8'h20, 3'h1, 24'h7d5678, 24'h7d0000, 24'h7dffff},
    '{8'hc7, 8'h08, 3'h1, 24'h0, 24'h0, 24'h0},
    '{8'hc7, 8'h09, 3'h0, 24'h0, 24'h0, 24'h0},
    '{8'hc7, 8'h08, 3'h0, 24'h0, 24'h000000, 24'h7fffff}};
  sfpes_core #(.PAGE_WRITE_CYCLES(20), .SECTOR_ERASE_CYCLES(40), .ARRAY_WIPE_CYCLES(AW)) i_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .cs_n(cs_n), .sck(sck), .io_in(io_in),
    .quad_enable(quad_enable), .block_guard_bits(block_guard_bits), .pg_rd_idx(pg_rd_idx),
    .so_out(so_out), .so_oe(so_oe), .busy_flag(busy_flag), .write_latch(write_latch),
    .deep_sleep(deep_sleep), .op_start(op_start), .op_kind(op_kind), .op_base(op_base),
    .op_last(op_last), .pg_rd_data(pg_rd_data));
  sfpes_host i_host (.cs_n(cs_n), .sck(sck), .io_in(io_in), .so_out(so_out));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic wclk(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : wclk
  task automatic check(input logic [49:0] e, input logic [49:0] a);
    cmp_count++;
    if (a !== e) begin
      n_errors++;
      $display("Error at %0t: expected %h got %h", $time, e, a);
    end
  endtask : check
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic send(input logic [7:0] op, input logic [23:0] a, input int hb, input int nb);
    i_host.frame({op, a, 8'h00}, hb, nb, op == sfpes_pkg::OP_QUAD_PAGE_WRITE);
    wclk(1);
  endtask : send
  task automatic unlock();
    send(sfpes_pkg::OP_WRITE_UNLOCK, 24'h0, 8, 0);
  endtask : unlock
  // Host polls busy before new work
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy_flag !== 1'b0 && n < 3000) begin
      wclk(1);
      n++;
    end
    check(50'h0, 50'(busy_flag));
  endtask : wait_idle
  // Pulse is stable at the falling edge, so no race with its launch
  always @(negedge clk_sys) begin
    cycles++;
    if (op_start === 1'b1)
      check(exp_q.size() > 0 ? exp_q.pop_front() : 50'h0, {op_kind, op_base, op_last});
    if (cycles == 40000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    sys_rst = 1'b1;
    quad_enable = 1'b0;
    block_guard_bits = 3'h0;
    pg_rd_idx = 8'h00;
    wclk(20);
    sys_rst = 1'b0;
    check(50'h0, 50'({busy_flag, write_latch, deep_sleep, op_start, so_oe, op_kind}));
    wclk(3);
    for (int i = 0; i < 260; i++) i_host.dat[i] = 8'(rnd());
    unlock();
    send(sfpes_pkg::OP_QUAD_PAGE_WRITE, 24'h0123f0, 32, 4);
    quad_enable = 1'b1;
    send(sfpes_pkg::OP_WRITE_LOCK, 24'h0, 8, 0);
    send(sfpes_pkg::OP_QUAD_PAGE_WRITE, 24'h0123f0, 32, 4);
    unlock();
    exp_q.push_back({sfpes_pkg::OPK_PROGRAM, 24'h012300, 24'h0123ff});
    send(sfpes_pkg::OP_QUAD_PAGE_WRITE, 24'h0123f0, 32, 260);
    wait_idle();
    for (int i = 0; i < 260; i++) exp_pg[8'(8'hf0 + i)] = i_host.dat[i];
    for (int i = 0; i < 256; i++) begin
      pg_rd_idx = 8'(i);
      wclk(3);
      check(50'(exp_pg[i]), 50'(pg_rd_data));
    end
    $display("Test quad write done");
    foreach (tc[i]) begin
      block_guard_bits = tc[i].guard;
      unlock();
      if (tc[i].last != 24'h0) exp_q.push_back({sfpes_pkg::OPK_ERASE, tc[i].base, tc[i].last});
      send(tc[i].op, tc[i].addr, int'(tc[i].hb), 0);
      wait_idle();
      check(50'(tc[i].last == 24'h0), 50'(write_latch));
    end
    $display("Test erase table done");
    unlock();
    exp_q.push_back({sfpes_pkg::OPK_ERASE, 24'h000000, 24'h7fffff});
    send(sfpes_pkg::OP_FULL_ARRAY_WIPE, 24'h0, 8, 0);
    send(sfpes_pkg::OP_SLEEP_ENTRY, 24'h0, 8, 0);
    send(sfpes_pkg::OP_WAKE_SIGNATURE, 24'h0, 32, 2);
    wait_idle();
    wclk(80);
    check(50'h0, 50'(deep_sleep));
    $display("Test busy refusal done");
    send(sfpes_pkg::OP_WAKE_SIGNATURE, 24'h0, 32, 2);
    check(50'({sfpes_pkg::SIGNATURE, sfpes_pkg::SIGNATURE}), 50'(i_host.rx));
    unlock();
    send(sfpes_pkg::OP_SLEEP_ENTRY, 24'h0, 9, 0);
    wclk(80);
    check(50'h0, 50'(deep_sleep));
    send(sfpes_pkg::OP_SLEEP_ENTRY, 24'h0, 8, 0);
    wclk(80);
    check(50'h1, 50'(deep_sleep));
    send(sfpes_pkg::OP_WRITE_LOCK, 24'h0, 8, 0);
    send(sfpes_pkg::OP_BLOCK_WIPE, 24'h010000, 32, 0);
    check(50'h3, 50'({deep_sleep, write_latch}));
    send(sfpes_pkg::OP_WAKE_SIGNATURE, 24'h0, 32, 2);
    check(50'({sfpes_pkg::SIGNATURE, sfpes_pkg::SIGNATURE}), 50'(i_host.rx));
    check(50'h1, 50'({deep_sleep, write_latch}));
    wclk(70);
    exp_q.push_back({sfpes_pkg::OPK_ERASE, 24'h001000, 24'h001fff});
    send(sfpes_pkg::OP_SMALL_ERASE, 24'h001000, 32, 0);
    wait_idle();
    check(50'h0, 50'(exp_q.size()));
    $display("Test sleep and wake done");
    report_and_stop();
  end
endmodule : tb_top
